// ### design/spi_host_defines.vh
// Constants of the external SPI party: timing counts and reset values.
// Assumes a 250 MHz system clock and a device core clock given below.
`ifndef SPI_HOST_DEFINES_VH
`define SPI_HOST_DEFINES_VH

// System clock rate in kHz
`define SPIH_CLK_KHZ          250000
// Core clock of the device on the far side, in kHz
`define SPIH_DEV_FCPU_KHZ     8000
// Least SCK half period: one device core period, rounded up
`define SPIH_MIN_HALF_CYC     ((`SPIH_CLK_KHZ + `SPIH_DEV_FCPU_KHZ - 1) / `SPIH_DEV_FCPU_KHZ)

// Reset values of the host configuration
`define SPIH_RST_HALF         8'h40
`define SPIH_RST_IDLE_LEVEL   1'b0
`define SPIH_RST_SAMPLE_EDGE  1'b0

// Edge index of the sixteenth SCK edge of a byte
`define SPIH_LAST_EDGE        4'hf

`endif

// ### design/spi_host_sync.v
// Two flip-flop synchroniser for pins coming from outside the clock domain.
// Assumes the inputs are plain levels; only the second stage is read.
`default_nettype none

module spi_host_sync #(
    parameter WIDTH = 3
) (
    input  wire             clk,      // System clock
    input  wire             reset_n,  // Asynchronous reset, active low
    input  wire [WIDTH-1:0] d,        // Asynchronous inputs
    output reg  [WIDTH-1:0] q         // Synchronised outputs
);

    reg [WIDTH-1:0] stage1;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= {WIDTH{1'b0}};
            q      <= {WIDTH{1'b0}};
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule // spi_host_sync

`default_nettype wire

// ### design/spi_host_clkgen.v
// Half-period tick generator for the SCK that the host drives.
// Assumes half_count is stable while run is high and at least 1.
`default_nettype none

module spi_host_clkgen (
    input  wire       clk,         // System clock
    input  wire       reset_n,     // Asynchronous reset, active low
    input  wire       run,         // Count while high, restart when low
    input  wire [7:0] half_count,  // Clock cycles per SCK half period
    output reg        tick         // One-cycle pulse per half period
);

    reg [7:0] count;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (!run) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (count == half_count - 8'h01) begin
            count <= 8'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule // spi_host_clkgen

`default_nettype wire

// ### design/spi_host.v
// External SPI party for the device's serial port: master or slave.
// Assumes the device pins are joined by the bench; pins use in/out/oe_n.
`include "spi_host_defines.vh"
`default_nettype none

// How it works
// - Full duplex on one master clock
// - Only master starts; slave waits for edges
// - Never clock device faster than fCPU/2
// - Device master's select held high always
// - Phase one: select low whole transmission
// - Phase zero: select high between bytes
// - Device software sets config before enable
// - Master flag clear: status then data read
// - Slave flag clear: status then data access
// - Slave clears flag before next completes
// - Same polarity and phase both ends
// - SCK idles at the polarity level
// - Change polarity only while disabled; host takes cfg_write in ST_IDLE even with port_on high
// - Fault clears by status read, control write
module spi_host (
    input  wire       clk,              // System clock, 250 MHz
    input  wire       reset_n,          // Asynchronous reset, active low
    input  wire       port_on,          // Host drives the link while high
    input  wire       host_is_master,   // High: host masters, low: host is slave
    input  wire       cfg_write,        // Strobe to take the three cfg values
    input  wire       cfg_idle_level,   // SCK idle level
    input  wire       cfg_sample_edge,  // High: sample on second edge
    input  wire [7:0] cfg_half_period,  // SCK half period in clock cycles
    input  wire       cmd_valid,        // Byte offered for the next transfer
    input  wire [7:0] cmd_data,         // Byte to send
    input  wire       cmd_last,         // Release select after this byte
    output reg        cmd_ready,        // Byte will be taken this cycle
    output reg        resp_valid,       // One-cycle pulse, byte received
    output reg  [7:0] resp_data,        // Byte received
    output reg        busy,             // Transfer in progress
    output reg        cfg_idle_level_q, // Configuration in force: idle level
    output reg        cfg_sample_q,     // Configuration in force: phase
    input  wire       sck_in,           // SCK pin level
    output reg        sck_out,          // SCK drive value
    output reg        sck_oe_n,         // SCK drive enable, active low
    input  wire       mosi_in,          // MOSI pin level
    output reg        mosi_out,         // MOSI drive value
    output reg        mosi_oe_n,        // MOSI drive enable, active low
    input  wire       miso_in,          // MISO pin level
    output reg        miso_out,         // MISO drive value
    output reg        miso_oe_n,        // MISO drive enable, active low
    output reg        ss_n              // Select pin of the device, active low
);

    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_SETUP = 2'd1;
    localparam [1:0] ST_SHIFT = 2'd2;
    localparam [1:0] ST_GAP   = 2'd3;

    localparam integer MIN_HALF_I = `SPIH_MIN_HALF_CYC;
    localparam [7:0]   MIN_HALF   = MIN_HALF_I[7:0];

    // Sample on leading edge for phase zero, trailing for phase one
    function sample_edge_now;
        input edge_lsb;
        input phase;
        begin
            sample_edge_now = (edge_lsb == phase);
        end
    endfunction

    reg  [7:0] half_period;
    reg  [1:0] state;
    reg  [3:0] edge_cnt;
    reg  [7:0] shifter;
    reg        release_after;
    reg        cur_master;
    reg        cur_on;
    reg        sck_prev;
    wire [2:0] pins_s;
    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;
    wire       tick;
    wire       run;
    wire       mode_change;
    wire       slave_edge;
    wire       in_bit;
    wire [7:0] next_shifter;
    wire       sample_now;

    // Pins from the device pass two flops before use
    spi_host_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({sck_in, mosi_in, miso_in}),
        .q       (pins_s)
    );

    assign sck_s  = pins_s[2];
    assign mosi_s = pins_s[1];
    assign miso_s = pins_s[0];

    assign run = cur_on && cur_master && (state != ST_IDLE);

    spi_host_clkgen u_clkgen (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (run),
        .half_count (half_period),
        .tick       (tick)
    );

    assign mode_change  = (host_is_master != cur_master) || (port_on != cur_on);
    assign slave_edge   = cur_on && !cur_master && (sck_s != sck_prev);
    assign in_bit       = cur_master ? miso_s : mosi_s;
    assign next_shifter = {shifter[6:0], in_bit};
    assign sample_now   = sample_edge_now(edge_cnt[0], cfg_sample_q);

    // Configuration only changes with the link quiet
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_period      <= `SPIH_RST_HALF;
            cfg_idle_level_q <= `SPIH_RST_IDLE_LEVEL;
            cfg_sample_q     <= `SPIH_RST_SAMPLE_EDGE;
        end else if (cfg_write && state == ST_IDLE && edge_cnt == 4'h0) begin
            // Clamp so SCK never exceeds half the device core clock
            if (cfg_half_period < MIN_HALF) begin
                half_period <= MIN_HALF;
            end else begin
                half_period <= cfg_half_period;
            end
            cfg_idle_level_q <= cfg_idle_level;
            cfg_sample_q     <= cfg_sample_edge;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state         <= ST_IDLE;
            edge_cnt      <= 4'h0;
            shifter       <= 8'h00;
            release_after <= 1'b1;
            cur_master    <= 1'b0;
            cur_on        <= 1'b0;
            sck_prev      <= 1'b0;
            cmd_ready     <= 1'b0;
            resp_valid    <= 1'b0;
            resp_data     <= 8'h00;
            busy          <= 1'b0;
            sck_out       <= 1'b0;
            sck_oe_n      <= 1'b1;
            mosi_out      <= 1'b0;
            mosi_oe_n     <= 1'b1;
            miso_out      <= 1'b0;
            miso_oe_n     <= 1'b1;
            ss_n          <= 1'b1;
        end else begin
            resp_valid <= 1'b0;
            sck_prev   <= sck_s;
            if (mode_change) begin
                // Any mode change aborts and parks the link
                cur_master <= host_is_master;
                cur_on     <= port_on;
                state      <= ST_IDLE;
                edge_cnt   <= 4'h0;
                cmd_ready  <= 1'b0;
                busy       <= 1'b0;
                ss_n       <= 1'b1;
                sck_out    <= cfg_idle_level_q;
                sck_oe_n   <= !(port_on && host_is_master);
                mosi_oe_n  <= !(port_on && host_is_master);
                miso_oe_n  <= !(port_on && !host_is_master);
            end else if (cur_on && cur_master) begin
                case (state)
                    ST_IDLE: begin
                        sck_out <= cfg_idle_level_q;
                        if (cmd_valid && cmd_ready) begin
                            shifter   <= cmd_data;
                            // Phase zero needs select high between bytes
                            release_after <= cmd_last || !cfg_sample_q;
                            ss_n      <= 1'b0;
                            cmd_ready <= 1'b0;
                            busy      <= 1'b1;
                            edge_cnt  <= 4'h0;
                            if (!cfg_sample_q) begin
                                mosi_out <= cmd_data[7];
                            end
                            state <= ST_SETUP;
                        end else begin
                            cmd_ready <= 1'b1;
                        end
                    end
                    ST_SETUP: begin
                        if (tick) begin
                            state <= ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        if (tick) begin
                            sck_out  <= !sck_out;
                            edge_cnt <= edge_cnt + 4'h1;
                            if (sample_now) begin
                                shifter <= next_shifter;
                            end else begin
                                mosi_out <= shifter[7];
                            end
                            if (edge_cnt == `SPIH_LAST_EDGE) begin
                                resp_valid <= 1'b1;
                                resp_data  <= sample_now ? next_shifter : shifter;
                                state      <= ST_GAP;
                            end
                        end
                    end
                    ST_GAP: begin
                        // Gap gives device software time to clear its flag
                        if (tick) begin
                            if (release_after) begin
                                ss_n <= 1'b1;
                            end
                            busy      <= 1'b0;
                            cmd_ready <= 1'b1;
                            state     <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end else if (cur_on) begin
                // Host is slave: keep the master's select high
                ss_n <= 1'b1;
                if (slave_edge) begin
                    cmd_ready <= 1'b0;
                    busy      <= (edge_cnt != `SPIH_LAST_EDGE);
                    edge_cnt  <= edge_cnt + 4'h1;
                    if (sample_now) begin
                        shifter <= next_shifter;
                    end else begin
                        miso_out <= shifter[7];
                    end
                    if (edge_cnt == `SPIH_LAST_EDGE) begin
                        resp_valid <= 1'b1;
                        resp_data  <= sample_now ? next_shifter : shifter;
                    end
                end else if (edge_cnt == 4'h0) begin
                    // Reply byte may be loaded only between bytes
                    if (cmd_valid && cmd_ready) begin
                        shifter   <= cmd_data;
                        cmd_ready <= 1'b0;
                        if (!cfg_sample_q) begin
                            miso_out <= cmd_data[7];
                        end
                    end else begin
                        cmd_ready <= 1'b1;
                    end
                end
            end else begin
                cmd_ready <= 1'b0;
                busy      <= 1'b0;
            end
        end
    end

endmodule // spi_host

`default_nettype wire

// ### design/dummy_unused_placeholder_never.v
`default_nettype none
`default_nettype wire

// ### sim/spi_host_asserts.sv
// Checker of the SPI host's user and pin ports.
// Assumes one clock domain; bound below to every spi_host.
`default_nettype none
module spi_host_asserts (
    input wire logic clk,              // Clock
    input wire logic reset_n,          // Reset, low
    input wire logic host_is_master,   // Role
    input wire logic cmd_valid,        // Offer
    input wire logic cmd_ready,        // Take
    input wire logic resp_valid,       // Reply
    input wire logic busy,             // Running
    input wire logic cfg_idle_level_q, // Idle level
    input wire logic sck_out,          // SCK value
    input wire logic sck_oe_n,         // SCK enable
    input wire logic mosi_oe_n,        // MOSI enable
    input wire logic ss_n              // Select
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] hcnt;
    // Cycles since SCK last moved
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) hcnt <= 8'h00;
        else hcnt <= $changed(sck_out) ? 8'h00 : hcnt + {7'h00, hcnt != 8'hff};
    end
    a_take_opens: assert property (cmd_valid && cmd_ready && host_is_master
        |=> !ss_n && busy && !cmd_ready) else $error("Frame not opened");
    a_busy_blocks: assert property (host_is_master && busy |-> !cmd_ready)
        else $error("Ready while busy");
    a_resp_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("Reply pulse too long");
    a_resp_framed: assert property (resp_valid && host_is_master |-> !ss_n && busy)
        else $error("Reply outside frame");
    a_gap_hold: assert property (resp_valid && host_is_master |=> !cmd_ready [*8])
        else $error("Gap too short");
    a_sck_idle: assert property (ss_n && $past(ss_n) && !sck_oe_n && !$past(sck_oe_n)
        && $stable(cfg_idle_level_q) |-> sck_out == cfg_idle_level_q) else $error("SCK not idle");
    a_half_min: assert property (!ss_n && $changed(sck_out) |-> hcnt >= 8'h1f)
        else $error("SCK half period short");
    a_slave_quiet: assert property (!host_is_master && !$past(host_is_master)
        |-> sck_oe_n && mosi_oe_n && ss_n) else $error("Slave drives link");
    c_master: cover property (resp_valid && host_is_master);
    c_slave: cover property (resp_valid && !host_is_master);
    c_idle_high: cover property (ss_n && cfg_idle_level_q && !sck_oe_n);
endmodule // spi_host_asserts
bind spi_host spi_host_asserts u_spi_host_asserts (
    .clk, .reset_n, .host_is_master, .cmd_valid, .cmd_ready, .resp_valid, .busy,
    .cfg_idle_level_q, .sck_out, .sck_oe_n, .mosi_oe_n, .ss_n
);
`default_nettype wire

// ### sim/spi_dev_model.sv
// Model of the device's serial port as slave.
// Assumes polarity and phase equal the host's.
`default_nettype none
module spi_dev_model (
    input  wire logic       ss_n, // Select, low
    input  wire logic       sck,  // Clock level
    input  wire logic       mosi, // Data in
    input  wire logic       pol,  // Idle level
    input  wire logic       pha,  // Late capture
    input  wire logic [7:0] tx,   // Reply byte
    output wire logic       miso, // Data out
    output var  logic [7:0] rx    // Byte received
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] o = 8'h00, i;
    int         e = 16;
    assign miso = ss_n ? ~o[7] : o[7]; // Released line inverts
    always @(negedge ss_n) begin
        o = tx;
        e = 0;
    end
    always @(sck) begin // Moves only on master edges
        if (!ss_n && e < 16) begin
            if ((sck != pol) ^ pha) i = {i[6:0], mosi};
            else if (!(pha && e == 0)) o = {o[6:0], 1'b0};
            e++;
            if (e == 16) rx = i;
        end
    end
endmodule // spi_dev_model
`default_nettype wire

// ### sim/tb_top.sv
// Bench of the SPI host against the device model.
// Assumes the bound checker; makes the link clock in slave mode.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk = 0, reset_n = 0, port_on = 1, host_is_master = 1, cfg_write = 0;
    logic            cfg_idle_level = 0, cfg_sample_edge = 0, cmd_valid = 0, cmd_last = 1;
    logic            tb_sck = 0, tb_drv = 0, tb_mosi = 0;
    logic [7:0]      cfg_half_period = 8'h20, cmd_data = 8'h00, dev_tx = 8'h00;
    wire logic       cmd_ready, resp_valid, busy, cfg_idle_level_q, cfg_sample_q, ss_n;
    wire logic       sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, dev_miso;
    wire logic [7:0] resp_data, dev_rx;
    wire logic       sck = !sck_oe_n ? sck_out : tb_drv ? tb_sck : cfg_idle_level;
    wire logic       mosi = !mosi_oe_n ? mosi_out : tb_drv ? tb_mosi : ~mosi_out;
    wire logic       miso = !miso_oe_n ? miso_out : dev_miso;
    int              miscompares = 0, samples_checked = 0;
    spi_host u_spi_host (
        .clk, .reset_n, .port_on, .host_is_master, .cfg_write, .cfg_idle_level, .cfg_sample_edge,
        .cfg_half_period, .cmd_valid, .cmd_data, .cmd_last, .cmd_ready, .resp_valid, .resp_data,
        .busy, .cfg_idle_level_q, .cfg_sample_q, .sck_in(sck), .sck_out, .sck_oe_n,
        .mosi_in(mosi), .mosi_out, .mosi_oe_n, .miso_in(miso), .miso_out, .miso_oe_n, .ss_n
    );
    spi_dev_model u_spi_dev_model (
        .ss_n, .sck, .mosi, .pol(cfg_idle_level), .pha(cfg_sample_edge), .tx(dev_tx),
        .miso(dev_miso), .rx(dev_rx)
    );
    task automatic chk(input logic [7:0] a, input logic [7:0] b);
        samples_checked++;
        if (a !== b) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, a, b);
        end
    endtask
    // Bounded wait: 0 ready, 1 reply, 2 idle
    task automatic await(input int k);
        int n;
        n = 0;
        @(negedge clk);
        while (n < 5000 && (k == 0 ? cmd_ready : k == 1 ? resp_valid : !busy) !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, n < 5000}, 8'h01);
    endtask
    task automatic offer(input logic [7:0] d);
        @(posedge clk);
        cmd_data  <= d;
        cmd_valid <= 1'b1;
        await(0);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic xfer_m(input logic pol, pha, input logic [7:0] h, tx, rx);
        @(posedge clk);
        {cfg_idle_level, cfg_sample_edge, cfg_half_period, cfg_write} <= {pol, pha, h, 1'b1};
        dev_tx <= rx;
        @(posedge clk);
        cfg_write <= 1'b0;
        offer(tx);
        await(1);
        chk(resp_data, rx);
        chk(dev_rx, tx);
        await(2);
        chk({5'h01, pol, pol, pha}, {4'h0, ss_n, sck, cfg_idle_level_q, cfg_sample_q});
    endtask
    task automatic xfer_s(input logic [7:0] tx, rx);
        logic [7:0] m;
        @(posedge clk);
        host_is_master <= 1'b0;
        repeat (4) @(posedge clk);
        offer(rx);
        #1 tb_drv = 1'b1;
        chk({6'h00, ss_n, sck_oe_n}, 8'h03);
        for (int i = 7; i >= 0; i--) begin
            tb_mosi = tx[i];
            #62.5 tb_sck = 1'b1;
            m[i] = miso;
            #62.5 tb_sck = 1'b0;
        end
        await(1);
        chk(resp_data, tx);
        chk(m, rx);
        tb_drv = 1'b0;
        @(posedge clk);
        host_is_master <= 1'b1;
    endtask
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        conclude;
    end
    initial begin
        repeat (3) @(posedge clk);
        chk({3'h0, ss_n, sck_oe_n, mosi_oe_n, miso_oe_n, busy}, 8'h1e);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        xfer_m(0, 1, 8'h04, 8'h5a, 8'hc3);
        xfer_m(1, 0, 8'h21, 8'hff, 8'h00);
        xfer_m(1, 1, 8'h20, 8'h96, 8'h69);
        xfer_m(0, 0, 8'h20, 8'ha5, 8'h3c);
        xfer_m(0, 0, 8'h20, 8'h01, 8'h80);
        xfer_s(8'hc9, 8'h37);
        conclude;
    end
endmodule // tb_top
`default_nettype wire
